// *** verilog/ppc_port.sv ***
// Port A and port B pin control, interrupt flags, mask and wake-up
//
// Added by the designer: the strobed register port and the address map.
module ppc_port (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire ppc_pkg::ppc_req_t i_req,
	output logic [7:0]            o_rdata,
	input  wire logic             i_eni,
	input  wire logic             i_interrupts_off_instruction,
	input  wire logic             i_tmr_ovf,
	input  wire logic             i_sleeping,
	input  wire logic [3:0]       i_pa,
	output logic [3:0]            o_pa,
	output logic [3:0]            o_pa_oe_n,
	output logic [2:0]            o_pa_pull_dn,
	output logic                  o_ropt_en,
	input  wire logic [7:0]       i_pb,
	output logic [7:0]            o_pb,
	output logic [7:0]            o_pb_oe_n,
	output logic [7:0]            o_pb_pull_up,
	output logic [3:0]            o_pb_pull_dn,
	output logic                  o_wdt_en,
	output logic                  o_irq,
	output logic [9:0]            o_irq_vector,
	output logic                  o_wake,
	output logic                  o_resume_next
);
	logic [3:0] pa_dir_q;
	logic [7:0] pb_dir_q;
	logic [3:0] pa_out_q;
	logic [7:0] pb_out_q;
	logic [7:0] pull_dn_q;
	logic [7:0] open_drain_q;
	logic [7:0] pull_high_q;
	logic       wdt_en_q;
	logic       int_sel_q;
	logic       ropt_en_q;
	logic [2:0] mask_q;
	logic [2:0] flag_q;
	logic [2:0] flag_d;
	logic [2:0] flag_set;
	logic       gie_q;
	logic [7:0] pb_latch_q;
	logic       int_pin_q;
	logic [7:0] rdata_d;
	logic [3:0] pa_read;
	logic [7:0] pb_read;
	logic       wr_hit_a;
	logic       wr_hit_b;
	logic       rd_b;

	assign wr_hit_a = i_req.wr && (i_req.addr == ppc_pkg::ADDR_PORT_A_DATA);
	assign wr_hit_b = i_req.wr && (i_req.addr == ppc_pkg::ADDR_PORT_B_DATA);
	assign rd_b     = i_req.rd && (i_req.addr == ppc_pkg::ADDR_PORT_B_DATA);

	// Direction registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_dir_q <= ppc_pkg::RST_PORT_A_DIR;
			pb_dir_q <= ppc_pkg::RST_PORT_B_DIR;
		end else if (i_req.wr) begin
			if (i_req.addr == ppc_pkg::ADDR_PORT_A_DIR)
				pa_dir_q <= i_req.wdata[3:0]; // R11
			if (i_req.addr == ppc_pkg::ADDR_PORT_B_DIR)
				pb_dir_q <= i_req.wdata; // R11
		end
	end

	// Output data latches
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_out_q <= ppc_pkg::RST_PORT_A_OUT;
			pb_out_q <= ppc_pkg::RST_PORT_B_OUT;
		end else begin
			if (wr_hit_a)
				pa_out_q <= i_req.wdata[3:0];
			if (wr_hit_b)
				pb_out_q <= i_req.wdata;
		end
	end

	// Pull and open-drain control registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pull_dn_q    <= ppc_pkg::RST_PULL_DOWN;
			open_drain_q <= ppc_pkg::RST_OPEN_DRAIN;
			pull_high_q  <= ppc_pkg::RST_PULL_HIGH;
		end else if (i_req.wr) begin
			if (i_req.addr == ppc_pkg::ADDR_PULL_DOWN)
				pull_dn_q <= i_req.wdata; // R13
			if (i_req.addr == ppc_pkg::ADDR_OPEN_DRAIN)
				open_drain_q <= i_req.wdata; // R12
			if (i_req.addr == ppc_pkg::ADDR_PULL_HIGH)
				pull_high_q <= i_req.wdata; // R1
		end
	end

	// Watchdog and pin function control
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wdt_en_q  <= ppc_pkg::RST_WDT_CTRL[2];
			int_sel_q <= ppc_pkg::RST_WDT_CTRL[1];
			ropt_en_q <= ppc_pkg::RST_WDT_CTRL[0];
		end else if (i_req.wr && i_req.addr == ppc_pkg::ADDR_WDT_CTRL) begin
			wdt_en_q  <= i_req.wdata[ppc_pkg::WDT_EN_BIT]; // R3
			int_sel_q <= i_req.wdata[ppc_pkg::INT_SEL_BIT]; // R4
			ropt_en_q <= i_req.wdata[ppc_pkg::ROPT_EN_BIT]; // R6
		end
	end

	// Interrupt mask
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			mask_q <= ppc_pkg::RST_IRQ_MASK;
		else if (i_req.wr && i_req.addr == ppc_pkg::ADDR_IRQ_MASK)
			mask_q <= i_req.wdata[2:0]; // R8 R10
	end

	// Global interrupt enable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			gie_q <= 1'b0;
		else if (i_eni)
			gie_q <= 1'b1; // R9
		else if (i_interrupts_off_instruction)
			gie_q <= 1'b0; // R9
	end

	// Port B snapshot taken on every read
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			pb_latch_q <= 8'h00;
		else if (rd_b)
			pb_latch_q <= i_pb; // R22
	end

	// Interrupt pin history for edge detection
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			int_pin_q <= 1'b1;
		else
			int_pin_q <= i_pb[0];
	end

	// Flag events; falling edge only counts while the pin is selected
	always_comb begin
		flag_set = 3'h0;
		flag_set[ppc_pkg::TMR_IRQ_BIT] = i_tmr_ovf;
		flag_set[ppc_pkg::CHG_IRQ_BIT] = !rd_b && (i_pb != pb_latch_q); // R14 R22
		flag_set[ppc_pkg::EXT_IRQ_BIT] = int_sel_q && int_pin_q && !i_pb[0]; // R5 R21
	end

	// Software may only clear by writing 0; a new event wins over the clear
	always_comb begin
		flag_d = flag_q;
		if (i_req.wr && i_req.addr == ppc_pkg::ADDR_IRQ_STATUS)
			flag_d = flag_q & i_req.wdata[2:0]; // R21
		flag_d = flag_d | flag_set;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			flag_q <= 3'h0;
		else
			flag_q <= flag_d;
	end

	// Pin read views
	always_comb begin
		pa_read = (pa_dir_q & i_pa) | (~pa_dir_q & pa_out_q); // R19
		if (ropt_en_q)
			pa_read[1:0] = i_pa[1:0]; // R7
		pb_read = (pb_dir_q & i_pb) | (~pb_dir_q & pb_out_q); // R19
		if (int_sel_q)
			pb_read[0] = i_pb[0]; // R5
	end

	// Read mux, answered one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		unique case (i_req.addr)
			ppc_pkg::ADDR_PORT_A_DATA: rdata_d = {4'h0, pa_read};
			ppc_pkg::ADDR_PORT_B_DATA: rdata_d = pb_read;
			ppc_pkg::ADDR_IRQ_STATUS:  rdata_d = {5'h00, flag_q & mask_q}; // R20
			ppc_pkg::ADDR_PORT_A_DIR:  rdata_d = {4'h0, pa_dir_q};
			ppc_pkg::ADDR_PORT_B_DIR:  rdata_d = pb_dir_q;
			ppc_pkg::ADDR_PULL_DOWN:   rdata_d = pull_dn_q;
			ppc_pkg::ADDR_OPEN_DRAIN:  rdata_d = open_drain_q;
			ppc_pkg::ADDR_PULL_HIGH:   rdata_d = pull_high_q; // R2
			ppc_pkg::ADDR_WDT_CTRL:
				rdata_d = {wdt_en_q, int_sel_q, 1'b0, ropt_en_q, 4'h0};
			ppc_pkg::ADDR_IRQ_MASK:    rdata_d = {5'h00, mask_q}; // R10
			default:                   rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_rdata <= 8'h00;
		else if (i_req.rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 8'h00;
	end

	// Port A drivers
	assign o_pa         = pa_out_q;
	assign o_pa_oe_n    = pa_dir_q; // R11 R19
	assign o_pa_pull_dn = ~pull_dn_q[2:0]; // R13
	assign o_ropt_en    = ropt_en_q; // R6

	// Port B drivers; open-drain pins drive only a low
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pb
			assign o_pb[g]      = pb_out_q[g];
			assign o_pb_oe_n[g] = pb_dir_q[g] ||
				(open_drain_q[g] && pb_out_q[g]); // R12 R19
		end
	endgenerate

	assign o_pb_pull_up = ~pull_high_q; // R1 R12
	assign o_pb_pull_dn = ~pull_dn_q[7:4]; // R13
	assign o_wdt_en     = wdt_en_q; // R3

	// Requests toward the core
	assign o_irq         = gie_q && |(flag_q & mask_q); // R9 R17
	assign o_irq_vector  = ppc_pkg::IRQ_VECTOR; // R17
	assign o_wake        = i_sleeping && flag_q[ppc_pkg::CHG_IRQ_BIT] &&
		mask_q[ppc_pkg::CHG_IRQ_BIT]; // R14
	assign o_resume_next = o_wake && !gie_q; // R17

	default clocking ck @(posedge i_clk); endclocking
	default disable iff (i_rst);

	pull_high_rb_a: assert property ( // R2
		i_req.wr && i_req.addr == ppc_pkg::ADDR_PULL_HIGH ##1
		i_req.rd && i_req.addr == ppc_pkg::ADDR_PULL_HIGH
		|=> o_rdata == $past(i_req.wdata, 2))
		else $error("pull-high readback differs");

	pull_up_pin_a: assert property ( // R1
		i_req.wr && i_req.addr == ppc_pkg::ADDR_PULL_HIGH
		|=> o_pb_pull_up == ~$past(i_req.wdata))
		else $error("pull-up enable not inverse of written bits");

	wdt_enable_a: assert property ( // R3
		i_req.wr && i_req.addr == ppc_pkg::ADDR_WDT_CTRL
		|=> o_wdt_en == $past(i_req.wdata[7]))
		else $error("watchdog enable not taken from bit 7");

	ext_edge_a: assert property ( // R21
		int_sel_q && $fell(i_pb[0]) |=> flag_q[ppc_pkg::EXT_IRQ_BIT])
		else $error("falling edge did not set external flag");

	ext_blocked_a: assert property ( // R5
		!int_sel_q && !flag_q[2] &&
		!(i_req.wr && i_req.addr == ppc_pkg::ADDR_WDT_CTRL)
		|=> !flag_q[ppc_pkg::EXT_IRQ_BIT])
		else $error("external flag set while path blocked");

	status_and_a: assert property ( // R20
		i_req.rd && i_req.addr == ppc_pkg::ADDR_IRQ_STATUS
		|=> o_rdata == {5'h00, $past(flag_q) & $past(mask_q)})
		else $error("status read is not flags and mask");

	change_flag_a: assert property ( // R22
		!rd_b && i_pb != pb_latch_q |=> flag_q[ppc_pkg::CHG_IRQ_BIT])
		else $error("port change did not raise flag");

	global_en_a: assert property ( // R9
		i_eni ##1 !i_interrupts_off_instruction [*2] |-> gie_q ##1 gie_q)
		else $error("global enable lost after enable instruction");

	dir_drive_a: assert property ( // R19
		i_req.wr && i_req.addr == ppc_pkg::ADDR_PORT_A_DIR
		|=> o_pa_oe_n == $past(i_req.wdata[3:0]))
		else $error("port A direction not applied");

	ropt_read_a: assert property ( // R7
		ropt_en_q && i_req.rd && i_req.addr == ppc_pkg::ADDR_PORT_A_DATA
		|=> o_rdata[1:0] == $past(i_pa[1:0]))
		else $error("option pins not read from pads");

	wake_vec_a: assert property ( // R17
		o_wake |-> (o_resume_next == !o_irq))
		else $error("wake resume choice disagrees with interrupt request");

	cov_ext_irq: cover property (int_sel_q && mask_q[2] && gie_q ##1 o_irq);
	cov_wake: cover property (i_sleeping ##[1:20] o_wake);
	cov_ropt: cover property (ropt_en_q && i_req.rd);
endmodule

// *** verilog/ppc_pkg.sv ***
// Constants and types for the port pin control and interrupt mask block
// What the document requires of the block and its software
// R1: Pull-high bit n serves port B pin n; 0 enables, 1 disables.
// R2: Pull-high control register reads back the value last written.
// R3: Watchdog control bit 7 enables the watchdog; 0 stops it, 1 runs it.
// R4: Bit 6 makes port B pin 0 the interrupt input; software sets it input.
// R5: Select 0 blocks the interrupt path; select 1 still reads its level.
// R6: Bit 4 enables resistor-option readout on port A pins 0 and 1.
// R7: With option enabled, fitted resistor reads 0, absent resistor reads 1.
// R8: Mask bit 0 timer overflow, bit 1 port change, bit 2 external; 1 enables.
// R9: One global enable; interrupts-on sets it, interrupts-off clears it.
// R10: Mask register is writable and readable; bits 3 to 7 unused.
// R11: Both ports tri-state; each pin's direction set by its direction bit.
// R12: Port B pins offer software pull-high and open-drain output.
// R13: Pull-downs only on port A pins 0-2 and port B pins 0-3.
// R14: A port B input change raises an interrupt and wakes from sleep.
// R15: Software keeps option pins as inputs while the option is enabled.
// R16: Software disables watchdog, reads port B, sets enables, then sleeps.
// R17: Change with global enable vectors to 008H, else resumes after sleep.
// R18: Watchdog hardware option must be set to use port-change wake-up.
// R19: Direction bit 1 makes the pin high impedance input, 0 an output.
// R20: Interrupt status reads as pending flags AND mask.
// R21: External flag set on pin falling edge, cleared by software only.
// R22: Port B latched on each read; flag set when inputs differ from latch.
package ppc_pkg;
	localparam logic [4:0] ADDR_PORT_A_DATA = 5'h05;
	localparam logic [4:0] ADDR_PORT_B_DATA = 5'h06;
	localparam logic [4:0] ADDR_IRQ_STATUS  = 5'h0F;
	localparam logic [4:0] ADDR_PORT_A_DIR  = 5'h15;
	localparam logic [4:0] ADDR_PORT_B_DIR  = 5'h16;
	localparam logic [4:0] ADDR_PULL_DOWN   = 5'h1B;
	localparam logic [4:0] ADDR_OPEN_DRAIN  = 5'h1C;
	localparam logic [4:0] ADDR_PULL_HIGH   = 5'h1D;
	localparam logic [4:0] ADDR_WDT_CTRL    = 5'h1E;
	localparam logic [4:0] ADDR_IRQ_MASK    = 5'h1F;

	localparam int WDT_EN_BIT   = 7;
	localparam int INT_SEL_BIT  = 6;
	localparam int ROPT_EN_BIT  = 4;
	localparam int TMR_IRQ_BIT  = 0;
	localparam int CHG_IRQ_BIT  = 1;
	localparam int EXT_IRQ_BIT  = 2;

	localparam logic [3:0] RST_PORT_A_DIR  = 4'hF;
	localparam logic [7:0] RST_PORT_B_DIR  = 8'hFF;
	localparam logic [7:0] RST_PULL_DOWN   = 8'hFF;
	localparam logic [7:0] RST_OPEN_DRAIN  = 8'h00;
	localparam logic [7:0] RST_PULL_HIGH   = 8'hFF;
	localparam logic [2:0] RST_WDT_CTRL    = 3'h4;
	localparam logic [2:0] RST_IRQ_MASK    = 3'h0;
	localparam logic [3:0] RST_PORT_A_OUT  = 4'h0;
	localparam logic [7:0] RST_PORT_B_OUT  = 8'h00;
	localparam logic [9:0] IRQ_VECTOR      = 10'h008;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ppc_req_t;
endpackage

// *** verification/ppc_pads.sv ***
// Board model: pad drivers, pulls and option resistors
module ppc_pads (
	input  wire logic       i_clk,
	input  wire logic [3:0] i_pa_o,
	input  wire logic [3:0] i_pa_oe_n,
	input  wire logic       i_ropt,
	input  wire logic [1:0] i_rex,
	input  wire logic [3:0] i_ext_pa,
	input  wire logic [7:0] i_pb_o,
	input  wire logic [7:0] i_pb_oe_n,
	input  wire logic [7:0] i_pu,
	input  wire logic [3:0] i_pd,
	input  wire logic [7:0] i_ext_pb,
	input  wire logic [7:0] i_ext_en,
	output logic [3:0]      o_pa,
	output logic [7:0]      o_pb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt_q = 8'hA5;
	logic [7:0] pd;
	logic [3:0] opt;
	assign pd = {4'h0, i_pd};
	assign opt = {2'b00, ~i_rex};
	always_ff @(posedge i_clk) flt_q <= ~flt_q;
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			if (!i_pb_oe_n[n]) o_pb[n] = i_pb_o[n];
			else if (i_ext_en[n]) o_pb[n] = i_ext_pb[n];
			else if (i_pu[n]) o_pb[n] = 1'b1;
			else if (pd[n]) o_pb[n] = 1'b0;
			else o_pb[n] = flt_q[n];
		end
		for (int n = 0; n < 4; n++) begin
			if (!i_pa_oe_n[n]) o_pa[n] = i_pa_o[n];
			else if (i_ropt && n < 2) o_pa[n] = opt[n];
			else o_pa[n] = i_ext_pa[n];
		end
	end
endmodule

// *** verification/ppc_port_tb.sv ***
// Self-checking bench for the port pin control block
module ppc_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              i_clk = 1'b0;
	logic              i_rst = 1'b1;
	ppc_pkg::ppc_req_t req = '0;
	logic [2:0]        ev = 3'h0;
	logic              slp = 1'b0;
	logic [3:0]        ext_pa = 4'h0;
	logic [7:0]        ext_pb = 8'h00;
	logic [7:0]        ext_en = 8'hFF;
	logic [1:0]        rex = 2'b00;
	logic [3:0]        pa, pa_o, pa_oe_n, pb_pd;
	logic [2:0]        pa_pd;
	logic [7:0]        pb, pb_o, pb_oe_n, pb_pu, rdata, v, d;
	logic [9:0]        vec;
	logic              ropt, wdt, irq, wake, resume;
	logic              rd_q = 1'b0;
	logic [7:0]        exp_q[$];
	string             nm_q[$];
	int                num_errors = 0, checks = 0, cyc = 0, seed = 8454;
	logic [4:0] ra[8] = '{ppc_pkg::ADDR_PORT_A_DIR, ppc_pkg::ADDR_PORT_B_DIR,
		ppc_pkg::ADDR_PULL_DOWN, ppc_pkg::ADDR_OPEN_DRAIN,
		ppc_pkg::ADDR_PULL_HIGH, ppc_pkg::ADDR_WDT_CTRL,
		ppc_pkg::ADDR_IRQ_MASK, 5'h07};
	logic [7:0] re[8] = '{8'h0F, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h80, 8'h00,
		8'h00};
	always #2.5 i_clk = ~i_clk;
	ppc_port uut (
		.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
		.i_eni(ev[0]), .i_interrupts_off_instruction(ev[1]), .i_tmr_ovf(ev[2]), .i_sleeping(slp),
		.i_pa(pa), .o_pa(pa_o), .o_pa_oe_n(pa_oe_n), .o_pa_pull_dn(pa_pd),
		.o_ropt_en(ropt), .i_pb(pb), .o_pb(pb_o), .o_pb_oe_n(pb_oe_n),
		.o_pb_pull_up(pb_pu), .o_pb_pull_dn(pb_pd), .o_wdt_en(wdt),
		.o_irq(irq), .o_irq_vector(vec), .o_wake(wake),
		.o_resume_next(resume)
	);
	ppc_pads pads (
		.i_clk(i_clk), .i_pa_o(pa_o), .i_pa_oe_n(pa_oe_n), .i_ropt(ropt),
		.i_rex(rex), .i_ext_pa(ext_pa), .i_pb_o(pb_o), .i_pb_oe_n(pb_oe_n),
		.i_pu(pb_pu), .i_pd(pb_pd), .i_ext_pb(ext_pb), .i_ext_en(ext_en),
		.o_pa(pa), .o_pb(pb)
	);
	task automatic results();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic done(string nm);
		$display("test %s done", nm);
	endtask
	task automatic wr(logic [4:0] a, logic [7:0] x);
		@(posedge i_clk);
		req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(string nm, logic [4:0] a, logic [7:0] e);
		@(posedge i_clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(e);
		nm_q.push_back(nm);
		@(posedge i_clk);
		req.rd <= 1'b0;
		#1;
	endtask
	task automatic pulse(logic [2:0] m);
		@(posedge i_clk);
		ev <= m;
		@(posedge i_clk);
		ev <= 3'h0;
		#1;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// Read data is compared in the cycle after each read strobe
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (rd_q) chk(nm_q.pop_front(), {2'h0, exp_q.pop_front()}, {2'h0, rdata});
		rd_q <= req.rd;
		if (cyc == 4000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (ra[i]) rd("reset", ra[i], re[i]);
		tick(1);
		chk("wdt_rst", 10'h001, {9'h0, wdt});
		chk("oe_b_rst", 10'h0FF, {2'h0, pb_oe_n});
		v = 8'($random(seed));
		wr(ppc_pkg::ADDR_PULL_HIGH, v);
		chk("pull_up", {2'h0, ~v}, {2'h0, pb_pu});
		rd("pull_high", ppc_pkg::ADDR_PULL_HIGH, v);
		ext_en = 8'h00;
		wr(ppc_pkg::ADDR_PULL_HIGH, 8'h00);
		rd("pulled", ppc_pkg::ADDR_PORT_B_DATA, 8'hFF);
		ext_en = 8'hFF;
		wr(ppc_pkg::ADDR_WDT_CTRL, 8'h00);
		chk("wdt_off", 10'h000, {8'h0, wdt, ropt});
		wr(ppc_pkg::ADDR_WDT_CTRL, 8'hFF);
		chk("wdt_on", 10'h003, {8'h0, wdt, ropt});
		rd("wdt_ctrl", ppc_pkg::ADDR_WDT_CTRL, 8'hD0);
		wr(ppc_pkg::ADDR_WDT_CTRL, 8'h00);
		wr(ppc_pkg::ADDR_IRQ_MASK, 8'hFF);
		rd("mask", ppc_pkg::ADDR_IRQ_MASK, 8'h07);
		done("registers");
		repeat (4) begin
			v = 8'($random(seed));
			d = 8'($random(seed));
			ext_pb = 8'($random(seed));
			ext_pa = 4'($random(seed));
			wr(ppc_pkg::ADDR_PORT_B_DIR, v);
			wr(ppc_pkg::ADDR_PORT_B_DATA, d);
			chk("oe_b", {2'h0, v}, {2'h0, pb_oe_n});
			chk("out_b", {2'h0, d}, {2'h0, pb_o});
			rd("port_b", ppc_pkg::ADDR_PORT_B_DATA, v & ext_pb | ~v & d);
			wr(ppc_pkg::ADDR_PORT_A_DIR, d);
			wr(ppc_pkg::ADDR_PORT_A_DATA, v);
			chk("oe_a", {6'h0, d[3:0]}, {6'h0, pa_oe_n});
			chk("out_a", {6'h0, v[3:0]}, {6'h0, pa_o});
			rd("port_a", ppc_pkg::ADDR_PORT_A_DATA,
				{4'h0, d[3:0] & ext_pa | ~d[3:0] & v[3:0]});
		end
		wr(ppc_pkg::ADDR_OPEN_DRAIN, 8'hFF);
		wr(ppc_pkg::ADDR_PORT_B_DIR, 8'h00);
		wr(ppc_pkg::ADDR_PORT_B_DATA, 8'h0F);
		chk("open_drain", 10'h00F, {2'h0, pb_oe_n});
		wr(ppc_pkg::ADDR_PULL_DOWN, 8'h00);
		chk("pull_dn", 10'h07F, {3'h0, pa_pd, pb_pd});
		wr(ppc_pkg::ADDR_PULL_DOWN, 8'hFF);
		wr(ppc_pkg::ADDR_OPEN_DRAIN, 8'h00);
		wr(ppc_pkg::ADDR_PORT_B_DIR, 8'hFF);
		wr(ppc_pkg::ADDR_PORT_A_DIR, 8'h0F);
		done("pins");
		ext_pa = 4'hC;
		wr(ppc_pkg::ADDR_WDT_CTRL, 8'h10);
		for (int i = 0; i < 4; i++) begin
			rex = 2'(i);
			rd("ropt", ppc_pkg::ADDR_PORT_A_DATA, {6'h03, ~rex});
		end
		wr(ppc_pkg::ADDR_WDT_CTRL, 8'h00);
		done("ropt");
		rd("snap", ppc_pkg::ADDR_PORT_B_DATA, ext_pb);
		wr(ppc_pkg::ADDR_IRQ_STATUS, 8'h00);
		wr(ppc_pkg::ADDR_IRQ_MASK, 8'h01);
		pulse(3'h1);
		pulse(3'h4);
		chk("irq_tmr", 10'h001, {9'h0, irq});
		rd("status", ppc_pkg::ADDR_IRQ_STATUS, 8'h01);
		wr(ppc_pkg::ADDR_IRQ_MASK, 8'h06);
		chk("irq_masked", 10'h000, {9'h0, irq});
		rd("status_m", ppc_pkg::ADDR_IRQ_STATUS, 8'h00);
		wr(ppc_pkg::ADDR_IRQ_MASK, 8'h01);
		pulse(3'h2);
		chk("irq_interrupts_off_instruction", 10'h000, {9'h0, irq});
		wr(ppc_pkg::ADDR_IRQ_STATUS, 8'h00);
		done("timer");
		wr(ppc_pkg::ADDR_IRQ_MASK, 8'h04);
		pulse(3'h1);
		for (int s = 0; s < 2; s++) begin
			wr(ppc_pkg::ADDR_WDT_CTRL, {1'b0, s[0], 6'h00});
			ext_pb[0] = 1'b1;
			tick(2);
			ext_pb[0] = 1'b0;
			tick(2);
			chk("irq_ext", {9'h0, s[0]}, {9'h0, irq});
		end
		rd("int_pin", ppc_pkg::ADDR_PORT_B_DATA, ext_pb);
		rd("status_x", ppc_pkg::ADDR_IRQ_STATUS, 8'h04);
		wr(ppc_pkg::ADDR_IRQ_STATUS, 8'h04);
		chk("irq_keep", 10'h001, {9'h0, irq});
		wr(ppc_pkg::ADDR_IRQ_STATUS, 8'h00);
		chk("irq_clr", 10'h000, {9'h0, irq});
		done("ext");
		wr(ppc_pkg::ADDR_WDT_CTRL, 8'h00);
		rd("snap2", ppc_pkg::ADDR_PORT_B_DATA, ext_pb);
		wr(ppc_pkg::ADDR_IRQ_STATUS, 8'h00);
		pulse(3'h2);
		wr(ppc_pkg::ADDR_IRQ_MASK, 8'h02);
		slp = 1'b1;
		tick(2);
		chk("no_wake", 10'h000, {9'h0, wake});
		ext_pb[7] = ~ext_pb[7];
		tick(2);
		chk("wake", 10'h003, {8'h0, wake, resume});
		pulse(3'h1);
		chk("irq_chg", 10'h002, {8'h0, irq, resume});
		chk("vector", 10'h008, vec);
		slp = 1'b0;
		done("wake");
		results();
	end
endmodule
